// ### logic/debug_trigger_cfg.svh
`ifndef DEBUG_TRIGGER_CFG_SVH
`define DEBUG_TRIGGER_CFG_SVH
// Byte offsets of the ten-byte debug space
`define OFS_COMP_A_HIGH 4'h0
`define OFS_COMP_A_LOW 4'h1
`define OFS_COMP_B_HIGH 4'h2
`define OFS_COMP_B_LOW 4'h3
`define OFS_FIFO_HIGH 4'h4
`define OFS_FIFO_LOW 4'h5
`define OFS_CONTROL 4'h6
`define OFS_TRIGGER 4'h7
`define OFS_STATUS 4'h8
`define OFS_FORCE_RESET 4'h9
`define COMP_RESET 8'h00
`define TRIGGER_RESET 8'h00
`define TRIGGER_MASK 8'hcf
`define TRG_TYPE_BIT 7
`define TRG_BEGIN_BIT 6
`define FORCE_RESET_BIT 0
`define FORCE_RESET_CYCLES 4'h4
`endif

// ### logic/debug_trigger_pkg.sv
package debug_trigger_pkg;
    typedef enum logic [3:0] {
        MODE_A_ONLY = 4'h0,
        MODE_A_OR_B = 4'h1,
        MODE_A_THEN_B = 4'h2,
        MODE_EVENT_B = 4'h3,
        MODE_A_THEN_EVENT_B = 4'h4,
        MODE_A_AND_B_DATA = 4'h5,
        MODE_A_NOT_B_DATA = 4'h6,
        MODE_INSIDE = 4'h7,
        MODE_OUTSIDE = 4'h8
    } trigger_mode_t;
endpackage

// ### logic/address_comparator.sv
`timescale 1ns/1ps
`include "debug_trigger_cfg.svh"
module address_comparator (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wrHigh,
    input wire logic wrLow,
    input wire logic [7:0] wrData,
    input wire logic [15:0] busAddr,
    output logic [15:0] compareValue,
    output logic equal,
    output logic below,
    output logic above
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            compareValue[15:8] <= `COMP_RESET;
        end else if (wrHigh) begin
            compareValue[15:8] <= wrData;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            compareValue[7:0] <= `COMP_RESET;
        end else if (wrLow) begin
            compareValue[7:0] <= wrData;
        end
    end

    assign equal = (busAddr == compareValue);
    assign below = (busAddr < compareValue);
    assign above = (busAddr > compareValue);
endmodule // address_comparator

// ### logic/debug_trigger_comparators.sv
`timescale 1ns/1ps
`include "debug_trigger_cfg.svh"
module debug_trigger_comparators (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    input wire logic debugWrite,
    input wire logic armed,
    input wire logic [7:0] fifoHigh,
    input wire logic [7:0] fifoLow,
    input wire logic [7:0] controlReg,
    input wire logic [7:0] statusReg,
    input wire logic busValid,
    input wire logic busIsData,
    input wire logic [15:0] busAddr,
    input wire logic opcodeExecuted,
    output logic tagRequest,
    output logic fifoTrigger,
    output logic beginTrace,
    output logic systemReset
);
    logic [7:0] trigger;
    logic [15:0] compA;
    logic [15:0] compB;
    logic eqA;
    logic eqB;
    logic belowA;
    logic aboveA;
    logic belowB;
    logic aboveB;
    logic seenA;
    logic rawMatch;
    logic tagMode;
    logic next_fifoTrigger;
    logic [3:0] resetCount;
    debug_trigger_pkg::trigger_mode_t mode;

    function automatic logic regHit(input logic [3:0] a, input logic [3:0] ofs);
        return a == ofs;
    endfunction

    function automatic logic eventOnly(input logic [3:0] m);
        return m == debug_trigger_pkg::MODE_EVENT_B || m == debug_trigger_pkg::MODE_A_THEN_EVENT_B;
    endfunction

    wire compWrite = regWrite && !armed;

    address_comparator compUnitA (
        .clk(clk),
        .rst_n(rst_n),
        .wrHigh(compWrite && regHit(regAddr, `OFS_COMP_A_HIGH)),
        .wrLow(compWrite && regHit(regAddr, `OFS_COMP_A_LOW)),
        .wrData(regWdata),
        .busAddr(busAddr),
        .compareValue(compA),
        .equal(eqA),
        .below(belowA),
        .above(aboveA)
    );

    address_comparator compUnitB (
        .clk(clk),
        .rst_n(rst_n),
        .wrHigh(compWrite && regHit(regAddr, `OFS_COMP_B_HIGH)),
        .wrLow(compWrite && regHit(regAddr, `OFS_COMP_B_LOW)),
        .wrData(regWdata),
        .busAddr(busAddr),
        .compareValue(compB),
        .equal(eqB),
        .below(belowB),
        .above(aboveB)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trigger <= `TRIGGER_RESET;
        end else if (regWrite && !armed && regHit(regAddr, `OFS_TRIGGER)) begin
            trigger <= regWdata & `TRIGGER_MASK;
        end
    end

    // Nine bytes mapped; the reset byte reads zero since it is write-only
    always_comb begin
        regRdata = 8'h00;
        if (regRead) begin
            case (regAddr)
                `OFS_COMP_A_HIGH: regRdata = compA[15:8];
                `OFS_COMP_A_LOW: regRdata = compA[7:0];
                `OFS_COMP_B_HIGH: regRdata = compB[15:8];
                `OFS_COMP_B_LOW: regRdata = compB[7:0];
                `OFS_FIFO_HIGH: regRdata = fifoHigh;
                `OFS_FIFO_LOW: regRdata = fifoLow;
                `OFS_CONTROL: regRdata = controlReg;
                `OFS_TRIGGER: regRdata = trigger;
                `OFS_STATUS: regRdata = statusReg;
                default: regRdata = 8'h00;
            endcase
        end
    end

    assign mode = debug_trigger_pkg::trigger_mode_t'(trigger[3:0]);
    assign tagMode = trigger[`TRG_TYPE_BIT];

    // A seen latch for the sequential modes; cleared when unarmed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seenA <= 1'b0;
        end else if (!armed) begin
            seenA <= 1'b0;
        end else if (busValid && eqA) begin
            seenA <= 1'b1;
        end
    end

    always_comb begin
        rawMatch = 1'b0;
        case (mode)
            debug_trigger_pkg::MODE_A_ONLY: rawMatch = eqA;
            debug_trigger_pkg::MODE_A_OR_B: rawMatch = eqA || eqB;
            debug_trigger_pkg::MODE_A_THEN_B: rawMatch = seenA && eqB;
            debug_trigger_pkg::MODE_EVENT_B: rawMatch = eqB;
            debug_trigger_pkg::MODE_A_THEN_EVENT_B: rawMatch = seenA && eqB;
            debug_trigger_pkg::MODE_A_AND_B_DATA: rawMatch = eqA && busIsData;
            debug_trigger_pkg::MODE_A_NOT_B_DATA: rawMatch = eqA && busIsData && !eqB;
            debug_trigger_pkg::MODE_INSIDE: rawMatch = !belowA && !aboveB;
            debug_trigger_pkg::MODE_OUTSIDE: rawMatch = belowA || aboveB;
            default: rawMatch = 1'b0;
        endcase
        rawMatch = rawMatch && busValid && armed;
    end

    // Tag mode waits for the tracker's execute report instead of the access
    assign tagRequest = tagMode && rawMatch;
    assign next_fifoTrigger = tagMode ? opcodeExecuted : rawMatch;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fifoTrigger <= 1'b0;
        end else begin
            fifoTrigger <= next_fifoTrigger;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            beginTrace <= 1'b0;
        end else begin
            beginTrace <= eventOnly(trigger[3:0]) || trigger[`TRG_BEGIN_BIT];
        end
    end

    // Reset held a few cycles so the whole system sees it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resetCount <= 4'h0;
        end else if (debugWrite && regHit(regAddr, `OFS_FORCE_RESET)
                     && regWdata[`FORCE_RESET_BIT]) begin
            resetCount <= `FORCE_RESET_CYCLES;
        end else if (resetCount != 4'h0) begin
            resetCount <= resetCount - 4'h1;
        end
    end

    assign systemReset = (resetCount != 4'h0);

    sequence aHit;
        armed && busValid && eqA;
    endsequence

    sequence bHit;
        armed && busValid && eqB;
    endsequence

    sequence forceWrite;
        debugWrite && regAddr == `OFS_FORCE_RESET && regWdata[`FORCE_RESET_BIT];
    endsequence

    chk_comp_write_block: assert property (@(posedge clk) disable iff (!rst_n)
        armed |=> $stable(compA) && $stable(compB))
        else $error("comparator changed while armed");

    chk_comp_a_take: assert property (@(posedge clk) disable iff (!rst_n)
        (regWrite && !armed && regAddr == `OFS_COMP_A_HIGH)
        |=> compA[15:8] == $past(regWdata))
        else $error("comparator A high write lost");

    chk_comp_b_take: assert property (@(posedge clk) disable iff (!rst_n)
        (regWrite && !armed && regAddr == `OFS_COMP_B_LOW)
        |=> compB[7:0] == $past(regWdata))
        else $error("comparator B low write lost");

    chk_trigger_bits_zero: assert property (@(posedge clk) disable iff (!rst_n)
        trigger[5:4] == 2'b00)
        else $error("trigger bits 5:4 not zero");

    chk_trig_write_block: assert property (@(posedge clk) disable iff (!rst_n)
        armed |=> $stable(trigger))
        else $error("trigger changed while armed");

    chk_trig_write_take: assert property (@(posedge clk) disable iff (!rst_n)
        (regWrite && !armed && regAddr == `OFS_TRIGGER)
        |=> trigger == ($past(regWdata) & `TRIGGER_MASK))
        else $error("trigger write lost");

    chk_read_bits_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (regRead && regAddr == `OFS_TRIGGER) |-> regRdata[5:4] == 2'b00)
        else $error("trigger read shows bits 5:4");

    chk_read_force_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (regRead && regAddr == `OFS_FORCE_RESET) |-> regRdata == 8'h00)
        else $error("force reset byte read not zero");

    chk_app_no_reset: assert property (@(posedge clk) disable iff (!rst_n)
        (regWrite && !debugWrite && !systemReset) |=> !systemReset)
        else $error("application write caused reset");

    chk_force_reset: assert property (@(posedge clk) disable iff (!rst_n)
        forceWrite |=> systemReset [*4])
        else $error("force reset did not hold");

    chk_force_reset_end: assert property (@(posedge clk) disable iff (!rst_n)
        forceWrite ##1 (!debugWrite) [*4] |=> !systemReset)
        else $error("force reset held too long");

    chk_trigger_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        (!tagMode && busValid && armed && mode == debug_trigger_pkg::MODE_A_ONLY && eqA)
        |=> fifoTrigger)
        else $error("A match missed trigger");

    chk_unarmed_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        (!tagMode && !armed) |=> !fifoTrigger)
        else $error("trigger while unarmed");

    chk_a_or_b: assert property (@(posedge clk) disable iff (!rst_n)
        (!tagMode && armed && busValid && mode == debug_trigger_pkg::MODE_A_OR_B
         && (eqA || eqB)) |=> fifoTrigger)
        else $error("A or B match missed");

    chk_b_before_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!tagMode && !seenA && mode == debug_trigger_pkg::MODE_A_THEN_B) |=> !fifoTrigger)
        else $error("B triggered before A");

    chk_a_then_b: assert property (@(posedge clk) disable iff (!rst_n)
        (!tagMode && seenA && mode == debug_trigger_pkg::MODE_A_THEN_B) ##0 bHit |=> fifoTrigger)
        else $error("B after A missed");

    chk_a_sets_seen: assert property (@(posedge clk) disable iff (!rst_n)
        aHit |=> seenA)
        else $error("A match not latched");

    chk_seen_clear: assert property (@(posedge clk) disable iff (!rst_n)
        !armed |=> !seenA)
        else $error("A latch kept while unarmed");

    chk_event_b: assert property (@(posedge clk) disable iff (!rst_n)
        (!tagMode && mode == debug_trigger_pkg::MODE_EVENT_B) ##0 bHit |=> fifoTrigger)
        else $error("event B missed");

    chk_a_then_event_b: assert property (@(posedge clk) disable iff (!rst_n)
        (!tagMode && seenA && mode == debug_trigger_pkg::MODE_A_THEN_EVENT_B)
        ##0 bHit |=> fifoTrigger)
        else $error("event B after A missed");

    chk_a_and_b_data: assert property (@(posedge clk) disable iff (!rst_n)
        (!tagMode && busIsData && mode == debug_trigger_pkg::MODE_A_AND_B_DATA)
        ##0 aHit |=> fifoTrigger)
        else $error("A data match missed");

    chk_a_not_b_data: assert property (@(posedge clk) disable iff (!rst_n)
        (!tagMode && busIsData && !eqB && mode == debug_trigger_pkg::MODE_A_NOT_B_DATA)
        ##0 aHit |=> fifoTrigger)
        else $error("A not B data match missed");

    chk_no_trig_high: assert property (@(posedge clk) disable iff (!rst_n)
        (trigger[3:0] > 4'h8 && !tagMode) |=> !fifoTrigger)
        else $error("reserved mode triggered");

    chk_inside_range: assert property (@(posedge clk) disable iff (!rst_n)
        (!tagMode && armed && busValid && mode == debug_trigger_pkg::MODE_INSIDE
         && busAddr >= compA && busAddr <= compB) |=> fifoTrigger)
        else $error("inside range missed");

    chk_outside_range: assert property (@(posedge clk) disable iff (!rst_n)
        (!tagMode && armed && busValid && mode == debug_trigger_pkg::MODE_OUTSIDE
         && (busAddr < compA || busAddr > compB)) |=> fifoTrigger)
        else $error("outside range missed");

    chk_event_begin: assert property (@(posedge clk) disable iff (!rst_n)
        eventOnly(trigger[3:0]) |=> beginTrace)
        else $error("event mode not begin");

    chk_begin_bit: assert property (@(posedge clk) disable iff (!rst_n)
        trigger[`TRG_BEGIN_BIT] |=> beginTrace)
        else $error("begin bit not followed");

    chk_end_trace: assert property (@(posedge clk) disable iff (!rst_n)
        (!trigger[`TRG_BEGIN_BIT] && !eventOnly(trigger[3:0])) |=> !beginTrace)
        else $error("end trace shown as begin");

    chk_tag_gate: assert property (@(posedge clk) disable iff (!rst_n)
        (tagMode && !opcodeExecuted) |=> !fifoTrigger)
        else $error("tag trigger without execute");

    chk_tag_request: assert property (@(posedge clk) disable iff (!rst_n)
        (tagMode && mode == debug_trigger_pkg::MODE_A_ONLY) ##0 aHit |-> tagRequest)
        else $error("tag match not sent to tracker");

    chk_force_no_tag: assert property (@(posedge clk) disable iff (!rst_n)
        !tagMode |-> !tagRequest)
        else $error("tag request in force mode");
endmodule // debug_trigger_comparators

// ### bench/core_bus_model.sv
`timescale 1ns/1ps
module core_bus_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req,
    input wire logic [15:0] reqAddr,
    input wire logic reqExec,
    output logic busValid,
    output logic busIsData,
    output logic [15:0] busAddr,
    output logic opcodeExecuted
);
    // Between cycles the address inverts each clock, so a stale address comes back every second idle cycle, with busValid low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busValid <= 1'b0;
            busIsData <= 1'b0;
            busAddr <= 16'h0000;
            opcodeExecuted <= 1'b0;
        end else begin
            busValid <= req;
            // An executed opcode fetch is not a data access
            busIsData <= req & ~reqExec;
            busAddr <= req ? reqAddr : ~busAddr;
            opcodeExecuted <= req & reqExec;
        end
    end
endmodule // core_bus_model

// ### bench/debug_trigger_comparators_test.sv
`timescale 1ns/1ps
`include "debug_trigger_cfg.svh"
module debug_trigger_comparators_test;
    logic clk, rst_n, regWrite, regRead, debugWrite, armed, req, reqExec, trig, tagSeen;
    logic busValid, busIsData, opcodeExecuted, tagRequest, fifoTrigger, beginTrace, systemReset;
    logic [3:0] regAddr;
    logic [7:0] regWdata, regRdata;
    logic [15:0] reqAddr, busAddr;
    int fails, n_compared;
    debug_trigger_comparators u_debug_trigger_comparators (.clk(clk), .rst_n(rst_n),
        .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
        .regRdata(regRdata), .debugWrite(debugWrite), .armed(armed), .fifoHigh(8'ha5),
        .fifoLow(8'h5a), .controlReg(8'h3c), .statusReg(8'hc3), .busValid(busValid),
        .busIsData(busIsData), .busAddr(busAddr), .opcodeExecuted(opcodeExecuted),
        .tagRequest(tagRequest), .fifoTrigger(fifoTrigger), .beginTrace(beginTrace),
        .systemReset(systemReset));
    core_bus_model u_core_bus_model (.clk(clk), .rst_n(rst_n), .req(req), .reqAddr(reqAddr),
        .reqExec(reqExec), .busValid(busValid), .busIsData(busIsData), .busAddr(busAddr),
        .opcodeExecuted(opcodeExecuted));
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic dbg);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= ~dbg;
        debugWrite <= dbg;
        regRead <= 1'b0;
        @(posedge clk);
        regWrite <= 1'b0;
        debugWrite <= 1'b0;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(negedge clk);
        chk8(regRdata, exp, "register read");
    endtask
    task automatic bus(input logic [15:0] a, input logic ex);
        @(posedge clk);
        req <= 1'b1;
        reqAddr <= a;
        reqExec <= ex;
        @(posedge clk);
        req <= 1'b0;
        @(negedge clk);
        tagSeen = tagRequest;
        @(negedge clk);
        trig = fifoTrigger;
        @(negedge clk);
        chk1(fifoTrigger, 1'b0, "trigger pulse width");
    endtask
    task automatic arm(input logic v);
        @(posedge clk);
        armed <= v;
    endtask
    task automatic t_regs();
        logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'ha5, 8'h5a, 8'h3c, 8'h00, 8'hc3,
            8'h00};
        for (int i = 0; i < 10; i++) rdchk(i[3:0], rv[i]);
        wr(`OFS_COMP_A_HIGH, 8'h12, 1'b0);
        wr(`OFS_COMP_A_LOW, 8'h34, 1'b0);
        wr(`OFS_COMP_B_HIGH, 8'h20, 1'b0);
        wr(`OFS_TRIGGER, 8'hff, 1'b0);
        rdchk(`OFS_TRIGGER, 8'hff & `TRIGGER_MASK);
        arm(1'b1);
        wr(`OFS_COMP_A_HIGH, 8'hee, 1'b0);
        wr(`OFS_COMP_B_LOW, 8'hee, 1'b0);
        wr(`OFS_TRIGGER, 8'h01, 1'b0);
        rdchk(`OFS_COMP_A_HIGH, 8'h12);
        rdchk(`OFS_COMP_A_LOW, 8'h34);
        rdchk(`OFS_COMP_B_HIGH, 8'h20);
        rdchk(`OFS_COMP_B_LOW, 8'h00);
        rdchk(`OFS_TRIGGER, 8'hcf);
        arm(1'b0);
    endtask
    task automatic t_modes();
        logic [3:0] md [13] = '{4'h0, 4'h0, 4'h1, 4'h7, 4'h7, 4'h8, 4'h8, 4'h9, 4'hf, 4'h3,
            4'h5, 4'h5, 4'h6};
        logic [15:0] ad [13] = '{16'h1234, 16'h2000, 16'h2000, 16'h1800, 16'h1000, 16'h1000,
            16'h1800, 16'h1234, 16'h1234, 16'h2000, 16'h1234, 16'h2000, 16'h1234};
        logic ex [13] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1,
            1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 13; i++) begin
            wr(`OFS_TRIGGER, {4'h0, md[i]}, 1'b0);
            arm(1'b1);
            bus(ad[i], 1'b0);
            chk1(trig, ex[i], "mode trigger");
            chk1(tagSeen, 1'b0, "force mode tag request");
            chk1(beginTrace, md[i] == 4'h3, "begin select");
            arm(1'b0);
        end
        for (int m = 2; m <= 4; m += 2) begin
            wr(`OFS_TRIGGER, m[7:0], 1'b0);
            arm(1'b1);
            bus(16'h2000, 1'b0);
            chk1(trig, 1'b0, "B before A");
            bus(16'h1234, 1'b0);
            bus(16'h2000, 1'b0);
            chk1(trig, 1'b1, "B after A");
            arm(1'b0);
        end
        wr(`OFS_TRIGGER, 8'h05, 1'b0);
        arm(1'b1);
        bus(16'h1234, 1'b1);
        chk1(trig, 1'b0, "A match on fetch");
        arm(1'b0);
        repeat (2) @(negedge clk);
        chk1(beginTrace, 1'b0, "end trace");
        wr(`OFS_TRIGGER, 8'h40, 1'b0);
        repeat (2) @(negedge clk);
        chk1(beginTrace, 1'b1, "begin trace");
    endtask
    task automatic t_tag();
        wr(`OFS_TRIGGER, 8'h80, 1'b0);
        arm(1'b1);
        bus(16'h1234, 1'b0);
        chk1(trig, 1'b0, "tag not executed");
        chk1(tagSeen, 1'b1, "tag request");
        bus(16'h1234, 1'b1);
        chk1(trig, 1'b1, "tag executed");
        arm(1'b0);
    endtask
    task automatic t_force();
        wr(`OFS_FORCE_RESET, 8'h01, 1'b0);
        @(negedge clk);
        chk1(systemReset, 1'b0, "application force reset");
        wr(`OFS_FORCE_RESET, 8'h01, 1'b1);
        @(negedge clk);
        chk1(systemReset, 1'b1, "debug force reset");
        repeat (`FORCE_RESET_CYCLES - 1) @(negedge clk);
        chk1(systemReset, 1'b1, "force reset held");
        @(negedge clk);
        chk1(systemReset, 1'b0, "force reset ends");
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        for (int k = 0; k < 20000; k++) @(posedge clk);
        fails++;
        test_done();
    end
    initial begin
        {rst_n, regWrite, regRead, debugWrite, armed, req, reqExec} = '0;
        regAddr = 4'h0;
        regWdata = 8'h00;
        reqAddr = 16'h0000;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_modes();
        t_tag();
        t_force();
        test_done();
    end
endmodule // debug_trigger_comparators_test
